// *** hw/fpm_pkg.sv ***
// Constants, register map and carrier types of the fieldbus process data mapper.
// Assumes one 100 MHz clock and a classic Wishbone slave port with 32-bit data.
// Notes on behaviour
// - Output word 3 source selector takes values 0 to 7, default 0.
// - Source 0 sends motor current in 0.1 A counts.
// - Source 1 sends output power in 0.01 kW counts.
// - Source 2 sends digital inputs, bit 0 is input 1.
// - Source 3 sends analog input 2, 0..1000 for 0..100.0 percent.
// - Source 4 sends heatsink temperature, 0..100 for 0..100 degrees.
// - Sources 5 and 6 send user registers 1 and 2; 7 sends monitor value.
// - Input word 4 selector 0 or 1; 0 drives ramps only when enabled.
// - Input word 4 selector 1 copies word into user register 4, writes blocked.
// - Input word 3 selector 0 drives torque when torque source equals 3.
// - Input word 3 selector 1 drives PID setpoint when PID source equals 1.
// - Input word 3 selector 2 copies word into user register 3, writes blocked.
// - Extra reply delay of 0 to 16 character times, default 0.
package fpm_pkg;

    localparam logic [7:0]  FPM_ADR_OUT3_SEL   = 8'h00;
    localparam logic [7:0]  FPM_ADR_IN4_SEL    = 8'h04;
    localparam logic [7:0]  FPM_ADR_IN3_SEL    = 8'h08;
    localparam logic [7:0]  FPM_ADR_DELAY      = 8'h0c;
    localparam logic [7:0]  FPM_ADR_CTRL       = 8'h10;
    localparam logic [7:0]  FPM_ADR_USER1      = 8'h14;
    localparam logic [7:0]  FPM_ADR_USER2      = 8'h18;
    localparam logic [7:0]  FPM_ADR_USER3      = 8'h1c;
    localparam logic [7:0]  FPM_ADR_USER4      = 8'h20;
    localparam logic [7:0]  FPM_ADR_CHAR_TICKS = 8'h24;
    localparam logic [7:0]  FPM_ADR_STATUS     = 8'h28;

    localparam logic [2:0]  FPM_OUT3_MAX   = 3'h7;
    localparam logic [0:0]  FPM_IN4_MAX    = 1'h1;
    localparam logic [1:0]  FPM_IN3_MAX    = 2'h2;
    localparam logic [4:0]  FPM_DELAY_MAX  = 5'h10;
    localparam logic [2:0]  FPM_SEL_RST    = 3'h0;
    localparam logic [4:0]  FPM_DELAY_RST  = 5'h00;

    localparam logic [2:0]  FPM_TORQUE_SRC_FIELDBUS = 3'h3;
    localparam logic [2:0]  FPM_PID_SRC_FIELDBUS    = 3'h1;

    // Control register fields.
    localparam int          FPM_CTRL_RAMP_EN_BIT  = 0;
    localparam int          FPM_CTRL_TQ_SRC_LSB   = 4;
    localparam int          FPM_CTRL_PID_SRC_LSB  = 8;

    // Character time: 11 bits at 115.2 kbit/s is about 95.5 us; the integer divide gives 9548 cycles.
    localparam int          FPM_CLK_HZ            = 100_000_000;
    localparam int          FPM_CHAR_BITS         = 11;
    localparam int          FPM_BAUD_DEFAULT      = 115_200;
    localparam logic [15:0] FPM_CHAR_TICKS_RST    =
        16'((FPM_CLK_HZ / FPM_BAUD_DEFAULT) * FPM_CHAR_BITS);

    typedef struct packed {
        logic [15:0] motor_current;
        logic [15:0] output_power;
        logic [15:0] digital_inputs;
        logic [15:0] analog_in2;
        logic [15:0] heatsink_temp;
        logic [15:0] monitor_value;
    } fpm_drive_meas_t;

    typedef struct packed {
        logic        ramp_valid;
        logic [15:0] ramp_word;
        logic        torque_valid;
        logic [15:0] torque_word;
        logic        pid_valid;
        logic [15:0] pid_word;
    } fpm_drive_cmd_t;

    typedef enum logic [1:0] {
        FPM_DLY_IDLE = 2'b00,
        FPM_DLY_WAIT = 2'b01,
        FPM_DLY_GO   = 2'b10
    } fpm_dly_state_t;

endpackage : fpm_pkg

// *** hw/fpm_reply_delay.sv ***
// Extra reply delay counted in character times for the RTU link.
// Assumes the protocol layer pulses req_ready once its own minimum gap has ended.
`timescale 1ns/10ps
`default_nettype none
module fpm_reply_delay
    import fpm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  delay_chars,
    input  wire logic [15:0] char_ticks,
    input  wire logic        req_ready,
    output logic             reply_go,
    output logic             busy
);

    fpm_dly_state_t state_r;
    logic [15:0]    tick_r;
    logic [4:0]     chars_r;
    logic           char_end;

    assign char_end = (tick_r == 16'h0001) || (char_ticks == 16'h0000);
    assign reply_go = (state_r == FPM_DLY_GO);
    assign busy     = (state_r != FPM_DLY_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // The delay is added after the minimum gap, so counting starts at req_ready.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= FPM_DLY_IDLE;
            tick_r  <= 16'h0000;
            chars_r <= 5'h00;
        end else begin
            case (state_r)
                FPM_DLY_IDLE: begin
                    if (req_ready) begin
                        tick_r  <= char_ticks;
                        chars_r <= delay_chars;
                        state_r <= (delay_chars == 5'h00) ? FPM_DLY_GO : FPM_DLY_WAIT;
                    end
                end
                FPM_DLY_WAIT: begin
                    if (char_end) begin
                        tick_r  <= char_ticks;
                        chars_r <= chars_r - 5'h01;
                        if (chars_r == 5'h01) begin
                            state_r <= FPM_DLY_GO;
                        end
                    end else begin
                        tick_r <= tick_r - 16'h0001;
                    end
                end
                FPM_DLY_GO: begin
                    state_r <= FPM_DLY_IDLE;
                end
                default: begin
                    state_r <= FPM_DLY_IDLE;
                end
            endcase
        end
    end

endmodule : fpm_reply_delay
`default_nettype wire

// *** hw/fpm_mapper.sv ***
// Top of the fieldbus process data mapper: Wishbone registers, word routing, reply delay.
// Assumes drive quantities and process words arrive on mclk; pin inputs are synchronised.
`timescale 1ns/10ps
`default_nettype none
module fpm_mapper
    import fpm_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    output logic                 wb_err_o,
    input  wire fpm_drive_meas_t meas,
    input  wire logic [7:0]      digital_in_pins,
    input  wire logic            pd_valid,
    input  wire logic [15:0]     process_input_word3,
    input  wire logic [15:0]     process_input_word4,
    output logic      [15:0]     process_output_word3,
    output fpm_drive_cmd_t       drive_cmd,
    input  wire logic            rtu_req_ready,
    output logic                 rtu_reply_go,
    output logic                 rtu_delay_busy
);

    logic [2:0]  output_word3_source_select_r;
    logic [0:0]  input_word4_destination_select_r;
    logic [1:0]  input_word3_destination_select_r;
    logic [4:0]  reply_extra_delay_chars_r;
    logic        fieldbus_ramp_control_enable_r;
    logic [2:0]  torque_reference_source_r;
    logic [2:0]  pid_setpoint_source_select_r;
    logic [15:0] user_reg1_r;
    logic [15:0] user_reg2_r;
    logic [15:0] user_reg3_r;
    logic [15:0] user_reg4_r;
    logic [15:0] char_ticks_r;
    logic [7:0]  din_meta_r;
    logic [7:0]  din_sync_r;
    logic [15:0] out_word_nxt;
    logic        wb_req;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_full;
    logic        adr_hit;
    logic [31:0] rd_nxt;
    logic [15:0] wdata16;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode. Every access is answered one cycle after it is seen; an
    // unmapped address answers with err so software sees the mistake.
    // A write lands at the edge where the master samples ack, not before it.
    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr_lo   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign wr_hi   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[1];
    assign wr_full = wr_lo && wr_hi;
    assign wdata16 = wb_dat_i[15:0];

    always_comb begin
        adr_hit = 1'b1;
        rd_nxt  = 32'h0000_0000;
        case (wb_adr_i)
            FPM_ADR_OUT3_SEL:   rd_nxt = {29'h0, output_word3_source_select_r};
            FPM_ADR_IN4_SEL:    rd_nxt = {31'h0, input_word4_destination_select_r};
            FPM_ADR_IN3_SEL:    rd_nxt = {30'h0, input_word3_destination_select_r};
            FPM_ADR_DELAY:      rd_nxt = {27'h0, reply_extra_delay_chars_r};
            FPM_ADR_CTRL:       rd_nxt = {21'h0, pid_setpoint_source_select_r, 1'b0,
                                          torque_reference_source_r, 3'h0,
                                          fieldbus_ramp_control_enable_r};
            FPM_ADR_USER1:      rd_nxt = {16'h0, user_reg1_r};
            FPM_ADR_USER2:      rd_nxt = {16'h0, user_reg2_r};
            FPM_ADR_USER3:      rd_nxt = {16'h0, user_reg3_r};
            FPM_ADR_USER4:      rd_nxt = {16'h0, user_reg4_r};
            FPM_ADR_CHAR_TICKS: rd_nxt = {16'h0, char_ticks_r};
            FPM_ADR_STATUS:     rd_nxt = {15'h0, rtu_delay_busy, out_word_nxt};
            default: begin
                adr_hit = 1'b0;
                rd_nxt  = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req && adr_hit;
            wb_err_o <= wb_req && !adr_hit;
            if (wb_req) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Selectors. A value beyond the range is dropped whole rather than
    // clipped, so a bad write never moves the routing somewhere unexpected.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            output_word3_source_select_r     <= FPM_SEL_RST;
            input_word4_destination_select_r <= FPM_SEL_RST[0:0];
            input_word3_destination_select_r <= FPM_SEL_RST[1:0];
            reply_extra_delay_chars_r        <= FPM_DELAY_RST;
        end else if (wr_lo) begin
            if (wb_adr_i == FPM_ADR_OUT3_SEL && wb_dat_i[31:0] <= 32'(FPM_OUT3_MAX)) begin
                output_word3_source_select_r <= wb_dat_i[2:0];
            end
            if (wb_adr_i == FPM_ADR_IN4_SEL && wb_dat_i[31:0] <= 32'(FPM_IN4_MAX)) begin
                input_word4_destination_select_r <= wb_dat_i[0:0];
            end
            if (wb_adr_i == FPM_ADR_IN3_SEL && wb_dat_i[31:0] <= 32'(FPM_IN3_MAX)) begin
                input_word3_destination_select_r <= wb_dat_i[1:0];
            end
            if (wb_adr_i == FPM_ADR_DELAY && wb_dat_i[31:0] <= 32'(FPM_DELAY_MAX)) begin
                reply_extra_delay_chars_r <= wb_dat_i[4:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fieldbus_ramp_control_enable_r <= 1'b0;
            torque_reference_source_r      <= 3'h0;
            pid_setpoint_source_select_r   <= 3'h0;
            char_ticks_r                   <= FPM_CHAR_TICKS_RST;
        end else begin
            if (wr_lo && wb_adr_i == FPM_ADR_CTRL) begin
                fieldbus_ramp_control_enable_r <= wb_dat_i[FPM_CTRL_RAMP_EN_BIT];
                torque_reference_source_r      <= wb_dat_i[FPM_CTRL_TQ_SRC_LSB +: 3];
            end
            if (wr_hi && wb_adr_i == FPM_ADR_CTRL) begin
                pid_setpoint_source_select_r <= wb_dat_i[FPM_CTRL_PID_SRC_LSB +: 3];
            end
            if (wr_full && wb_adr_i == FPM_ADR_CHAR_TICKS) begin
                char_ticks_r <= wdata16;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User registers. While a process word owns register 3 or 4, bus writes
    // to it are ignored; a process word landing in the same cycle wins anyway.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            user_reg1_r <= 16'h0000;
            user_reg2_r <= 16'h0000;
            user_reg3_r <= 16'h0000;
            user_reg4_r <= 16'h0000;
        end else begin
            if (wr_full && wb_adr_i == FPM_ADR_USER1) begin
                user_reg1_r <= wdata16;
            end
            if (wr_full && wb_adr_i == FPM_ADR_USER2) begin
                user_reg2_r <= wdata16;
            end
            if (input_word3_destination_select_r == 2'h2) begin
                if (pd_valid) begin
                    user_reg3_r <= process_input_word3;
                end
            end else if (wr_full && wb_adr_i == FPM_ADR_USER3) begin
                user_reg3_r <= wdata16;
            end
            if (input_word4_destination_select_r == 1'h1) begin
                if (pd_valid) begin
                    user_reg4_r <= process_input_word4;
                end
            end else if (wr_full && wb_adr_i == FPM_ADR_USER4) begin
                user_reg4_r <= wdata16;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital input pins come from outside the clock domain.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            din_meta_r <= 8'h00;
            din_sync_r <= 8'h00;
        end else begin
            din_meta_r <= digital_in_pins;
            din_sync_r <= din_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output word 3. Measurements arrive already in the scaled units.
    always_comb begin
        case (output_word3_source_select_r)
            3'h0:    out_word_nxt = meas.motor_current;
            3'h1:    out_word_nxt = meas.output_power;
            3'h2:    out_word_nxt = {8'h00, din_sync_r};
            3'h3:    out_word_nxt = meas.analog_in2;
            3'h4:    out_word_nxt = meas.heatsink_temp;
            3'h5:    out_word_nxt = user_reg1_r;
            3'h6:    out_word_nxt = user_reg2_r;
            3'h7:    out_word_nxt = meas.monitor_value;
            default: out_word_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            process_output_word3 <= 16'h0000;
        end else begin
            process_output_word3 <= out_word_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input word routing to drive functions, each gated by its enabling setting.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            drive_cmd <= '0;
        end else begin
            drive_cmd.ramp_valid   <= (input_word4_destination_select_r == 1'h0)
                                      && fieldbus_ramp_control_enable_r;
            drive_cmd.torque_valid <= (input_word3_destination_select_r == 2'h0)
                                      && (torque_reference_source_r == FPM_TORQUE_SRC_FIELDBUS);
            drive_cmd.pid_valid    <= (input_word3_destination_select_r == 2'h1)
                                      && (pid_setpoint_source_select_r == FPM_PID_SRC_FIELDBUS);
            if (pd_valid && input_word4_destination_select_r == 1'h0) begin
                drive_cmd.ramp_word <= process_input_word4;
            end
            if (pd_valid && input_word3_destination_select_r == 2'h0) begin
                drive_cmd.torque_word <= process_input_word3;
            end
            if (pd_valid && input_word3_destination_select_r == 2'h1) begin
                drive_cmd.pid_word <= process_input_word3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    fpm_reply_delay u_delay (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .delay_chars (reply_extra_delay_chars_r),
        .char_ticks  (char_ticks_r),
        .req_ready   (rtu_req_ready),
        .reply_go    (rtu_reply_go),
        .busy        (rtu_delay_busy)
    );

endmodule : fpm_mapper
`default_nettype wire

// *** tb/fpm_mapper_properties.sv ***
// Concurrent checks on the ports of the process data mapper, bound into fpm_mapper.
// Assumes the single mclk domain with sys_rst synchronous and active high.
`timescale 1ns/10ps
`default_nettype none
module fpm_mapper_properties
    import fpm_pkg::*;
(
    input wire logic           mclk,
    input wire logic           sys_rst,
    input wire logic           wb_cyc_i,
    input wire logic           wb_stb_i,
    input wire logic           wb_ack_o,
    input wire logic           wb_err_o,
    input wire logic           pd_valid,
    input wire logic [15:0]    process_input_word3,
    input wire logic [15:0]    process_input_word4,
    input wire logic [15:0]    process_output_word3,
    input wire fpm_drive_cmd_t drive_cmd,
    input wire logic           rtu_req_ready,
    input wire logic           rtu_reply_go,
    input wire logic           rtu_delay_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    bus_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered in the next cycle");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    answer_excl_a: assert property (
        !(wb_ack_o && wb_err_o))
        else $error("bus ack and err together");
    // Reset must leave every routed output cleared at the first edge after release.
    reset_clear_a: assert property (
        $fell(sys_rst) |-> process_output_word3 == 16'h0000 && drive_cmd == '0 && !rtu_delay_busy)
        else $error("outputs not cleared by reset");
    reply_pulse_a: assert property (
        rtu_reply_go |=> !rtu_reply_go)
        else $error("reply go longer than one cycle");
    reply_busy_a: assert property (
        rtu_req_ready && !rtu_delay_busy |=> rtu_delay_busy)
        else $error("request not taken by the reply delay");
    busy_cause_a: assert property (
        $rose(rtu_delay_busy) |-> $past(rtu_req_ready))
        else $error("delay busy without a request");
    ramp_route_a: assert property (
        pd_valid && drive_cmd.ramp_valid |=> drive_cmd.ramp_word == $past(process_input_word4))
        else $error("ramp word not taken from input word 4");
    torque_route_a: assert property (
        pd_valid && drive_cmd.torque_valid |=> drive_cmd.torque_word == $past(process_input_word3))
        else $error("torque word not taken from input word 3");
    pid_route_a: assert property (
        pd_valid && drive_cmd.pid_valid |=> drive_cmd.pid_word == $past(process_input_word3))
        else $error("pid word not taken from input word 3");
endmodule : fpm_mapper_properties
bind fpm_mapper fpm_mapper_properties chk (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
    .pd_valid, .process_input_word3, .process_input_word4, .process_output_word3, .drive_cmd,
    .rtu_req_ready, .rtu_reply_go, .rtu_delay_busy);
`default_nettype wire

// *** tb/fpm_master_model.sv ***
// Behavioural fieldbus master: sends cyclic process words and RTU requests.
// Assumes the bench calls its tasks and waits for busy to fall between requests.
`timescale 1ns/10ps
`default_nettype none
module fpm_master_model (
    input  wire logic  mclk,
    output logic       pd_valid,
    output logic [15:0] process_input_word3,
    output logic [15:0] process_input_word4,
    output logic       rtu_req_ready
);
    initial begin
        pd_valid = 1'b0;
        process_input_word3 = 16'h0000;
        process_input_word4 = 16'h0000;
        rtu_req_ready = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // Protected user registers are only ever fed through the process words here.
    task send_pd(input logic [15:0] w3, input logic [15:0] w4);
        @(posedge mclk);
        pd_valid <= 1'b1;
        process_input_word3 <= w3;
        process_input_word4 <= w4;
        @(posedge mclk);
        pd_valid <= 1'b0;
        // Words are not held after the pulse, so a late sample shows wrong data.
        process_input_word3 <= ~w3;
        process_input_word4 <= ~w4;
    endtask : send_pd
    task ask();
        @(posedge mclk);
        rtu_req_ready <= 1'b1;
        @(posedge mclk);
        rtu_req_ready <= 1'b0;
    endtask : ask
endmodule : fpm_master_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the process data mapper with a fieldbus master model.
// Assumes the design package; the char ticks register is lowered to keep delays short.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import fpm_pkg::*;
    logic            mclk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            wb_cyc_i = 1'b0;
    logic            wb_stb_i = 1'b0;
    logic            wb_we_i = 1'b0;
    logic [7:0]      wb_adr_i = 8'h00;
    logic [3:0]      wb_sel_i = 4'hf;
    logic [3:0]      sl = 4'hf;
    logic [31:0]     wb_dat_i = 32'h0;
    logic [31:0]     wb_dat_o, q, seed = 32'h85013557;
    logic            wb_ack_o, wb_err_o, e, pd_valid, rtu_req_ready, rtu_reply_go, rtu_delay_busy;
    fpm_drive_meas_t meas = '0;
    logic [7:0]      digital_in_pins = 8'h00;
    logic [15:0]     process_input_word3, process_input_word4, process_output_word3;
    fpm_drive_cmd_t  drive_cmd;
    int              bad_count = 0;
    int              tests_run = 0;
    logic [7:0]      adr_t [4] = '{FPM_ADR_OUT3_SEL, FPM_ADR_IN4_SEL, FPM_ADR_IN3_SEL, FPM_ADR_DELAY};
    logic [31:0]     max_t [4] = '{32'h7, 32'h1, 32'h2, 32'h10};
    int              dl_t [4] = '{0, 1, 2, 16};
    always #5 mclk = ~mclk;
    fpm_mapper dut (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .meas, .digital_in_pins, .pd_valid, .process_input_word3,
        .process_input_word4, .process_output_word3, .drive_cmd, .rtu_req_ready, .rtu_reply_go,
        .rtu_delay_busy);
    fpm_master_model pm (.mclk, .pd_valid, .process_input_word3, .process_input_word4, .rtu_req_ready);
    ////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task end_sim();
        $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // Classic single cycle; the request is held until ack or err is sampled.
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sl;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
        end
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i == 20) begin
            bad_count++;
            end_sim();
        end
    endtask : wb
    ////////////////////////////////////////////////////////////
    initial begin
        int          i, n, s3, s4, c;
        logic [15:0] u1, u2, w3, w4, r;
        logic [15:0] ex [8];
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        for (i = 0; i < 4; i++) begin
            wb(1'b0, adr_t[i], 32'h0);
            chk("selector reset", 32'h0, q);
            wb(1'b1, adr_t[i], max_t[i] + 32'h1);
            wb(1'b0, adr_t[i], 32'h0);
            chk("selector over range", 32'h0, q);
            wb(1'b1, adr_t[i], max_t[i]);
            wb(1'b0, adr_t[i], 32'h0);
            chk("selector at max", max_t[i], q);
            wb(1'b1, adr_t[i], 32'h0);
        end
        wb(1'b0, FPM_ADR_CHAR_TICKS, 32'h0);
        chk("char ticks reset", 32'(FPM_CHAR_TICKS_RST), q);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, 32'(e));
        sl = 4'h2;
        wb(1'b1, FPM_ADR_OUT3_SEL, 32'h3);
        sl = 4'hf;
        wb(1'b0, FPM_ADR_OUT3_SEL, 32'h0);
        chk("lane gated write", 32'h0, q);
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            u1 = 16'(rnd());
            u2 = 16'(rnd());
            meas <= {rnd(), rnd(), rnd()};
            digital_in_pins <= 8'(rnd());
            wb(1'b1, FPM_ADR_USER1, 32'(u1));
            wb(1'b1, FPM_ADR_USER2, 32'(u2));
            wb(1'b1, FPM_ADR_OUT3_SEL, 32'(i));
            repeat (4) @(posedge mclk);
            #1;
            ex = '{meas.motor_current, meas.output_power, {8'h00, digital_in_pins}, meas.analog_in2,
                   meas.heatsink_temp, u1, u2, meas.monitor_value};
            chk("output word3", 32'(ex[i]), 32'(process_output_word3));
            wb(1'b0, FPM_ADR_STATUS, 32'h0);
            chk("status word", 32'(ex[i]), q);
        end
        $display("test output word done");
        for (c = 0; c < 2; c++) begin
            wb(1'b1, FPM_ADR_CTRL, (c == 0) ? 32'h131 : 32'h0);
            for (s3 = 0; s3 < 3; s3++) begin
                for (s4 = 0; s4 < 2; s4++) begin
                    wb(1'b1, FPM_ADR_IN3_SEL, 32'(s3));
                    wb(1'b1, FPM_ADR_IN4_SEL, 32'(s4));
                    w3 = 16'(rnd());
                    w4 = 16'(rnd());
                    pm.send_pd(w3, w4);
                    repeat (2) @(posedge mclk);
                    #1;
                    chk("ramp valid", 32'(s4 == 0 && c == 0), 32'(drive_cmd.ramp_valid));
                    chk("torque valid", 32'(s3 == 0 && c == 0), 32'(drive_cmd.torque_valid));
                    chk("pid valid", 32'(s3 == 1 && c == 0), 32'(drive_cmd.pid_valid));
                    if (s4 == 0 && c == 0) chk("ramp word", 32'(w4), 32'(drive_cmd.ramp_word));
                    if (s3 == 0 && c == 0) chk("torque word", 32'(w3), 32'(drive_cmd.torque_word));
                    if (s3 == 1 && c == 0) chk("pid word", 32'(w3), 32'(drive_cmd.pid_word));
                    r = 16'(rnd());
                    wb(1'b1, FPM_ADR_USER3, 32'(r));
                    wb(1'b0, FPM_ADR_USER3, 32'h0);
                    chk("user reg3", 32'((s3 == 2) ? w3 : r), q);
                    wb(1'b1, FPM_ADR_USER4, 32'(r));
                    wb(1'b0, FPM_ADR_USER4, 32'h0);
                    chk("user reg4", 32'((s4 == 1) ? w4 : r), q);
                end
            end
        end
        $display("test input routing done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        wb(1'b0, FPM_ADR_IN3_SEL, 32'h0);
        chk("selector mid reset", 32'h0, q);
        wb(1'b1, FPM_ADR_CHAR_TICKS, 32'h3);
        for (i = 0; i < 4; i++) begin
            wb(1'b1, FPM_ADR_DELAY, 32'(dl_t[i]));
            pm.ask();
            for (n = 1; n < 100; n++) begin
                #1;
                if (rtu_reply_go === 1'b1) break;
                @(posedge mclk);
            end
            chk("reply delay cycles", 32'(1 + dl_t[i] * 3), 32'(n));
            repeat (2) @(posedge mclk);
        end
        $display("test reply delay done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
